// ---- emtx_regs.svh ----
`ifndef EMTX_REGS_SVH
`define EMTX_REGS_SVH
// Core clock period and bit times per link speed, in ns
`define EMTX_CLK_NS 4
`define EMTX_BIT_NS_100 10
`define EMTX_BIT_NS_10 100
// Cycles per two bit times (exact at both speeds)
`define EMTX_PAIR_CYC_100 ((2 * `EMTX_BIT_NS_100) / `EMTX_CLK_NS)
`define EMTX_PAIR_CYC_10 ((2 * `EMTX_BIT_NS_10) / `EMTX_CLK_NS)
// Gap, slot and pause quantum, in bit times, then in bit pairs
`define EMTX_IPG_BITS 96
`define EMTX_SLOT_BITS 512
`define EMTX_IPG_PAIRS (`EMTX_IPG_BITS / 2)
`define EMTX_SLOT_PAIRS (`EMTX_SLOT_BITS / 2)
// Collision limits
`define EMTX_MAX_COL 5'h10
`define EMTX_BO_LIMIT 5'h0A
// Pause values sent for off and on
`define EMTX_PAUSE_MAX 16'hFFFF
`define EMTX_PAUSE_ZERO 16'h0000
// Back-off random source
`define EMTX_LFSR_SEED 16'hACE1
`endif

// ---- emtx_pkg.sv ----
package emtx_pkg;
   // Transmit scheduler states, Gray coded along the collision and back-off path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_TX = 3'h1,
      ST_BOFF = 3'h3,
      ST_IPG = 3'h2,
      ST_BP = 3'h6,
      ST_BPGAP = 3'h7
   } emtx_state_type;

   // Command to the transmit datapath
   typedef struct packed {
      logic start;
      logic flow;
      logic [15:0] pause_time;
      logic abort;
      logic drop;
   } emtx_txcmd_type;

   // Status events to the host
   typedef struct packed {
      logic excess_col;
      logic late_col;
   } emtx_evt_type;
endpackage

// ---- emtx_mac.sv ----
`timescale 1ns/100ps
`include "emtx_regs.svh"

module emtx_mac
   import emtx_pkg::*;
#(
   parameter int FREE_W = 12,
   parameter logic [11:0] XOFF_THR = 12'h100,
   parameter logic [11:0] XON_THR = 12'h300,
   parameter int BP_ON_PAIRS = 2000,
   parameter int BP_GAP_PAIRS = 8
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Link mode
   input wire logic link_up_i,
   input wire logic full_duplex_i,
   input wire logic speed_100_i,
   input wire logic bp_enable_i,
   // PHY carrier and collision pins
   input wire logic crs_i,
   input wire logic col_i,
   // Frame queue and datapath
   input wire logic tx_valid_i,
   input wire logic tx_ctrl_i,
   input wire logic tx_end_i,
   input wire logic [FREE_W-1:0] free_i,
   // Received pause frame
   input wire logic rx_pause_i,
   input wire logic [15:0] rx_quanta_i,
   // Command, carrier and status
   output emtx_txcmd_type cmd_o,
   output logic bp_carrier_o,
   output logic paused_o,
   output emtx_evt_type evt_o
);

   localparam logic [5:0] P100_LAST = 6'(`EMTX_PAIR_CYC_100 - 1);
   localparam logic [5:0] P10_LAST = 6'(`EMTX_PAIR_CYC_10 - 1);
   // One spare tick: the first tick of the gap is only partial
   localparam logic [17:0] IPG_LAST = 18'(`EMTX_IPG_PAIRS);
   localparam logic [8:0] SLOT_PAIRS = 9'(`EMTX_SLOT_PAIRS);
   localparam logic [7:0] QUANT_LAST = 8'(`EMTX_SLOT_PAIRS - 1);
   localparam logic [17:0] BP_ON_LAST = 18'(BP_ON_PAIRS - 1);
   localparam logic [17:0] BP_GAP_LAST = 18'(BP_GAP_PAIRS - 1);

   emtx_state_type state_r;
   logic [2:0] crs_s_r, col_s_r;
   logic crs_q_r, col_q_r, col_d_r, tick_r;
   logic [5:0] pair_cnt_r;
   logic [7:0] quant_cnt_r;
   logic [15:0] pause_r, fc_time_r, lfsr_r;
   logic fc_active_r, fc_pend_r, after_col_r, cur_flow_r;
   logic [17:0] cnt_r;
   logic [8:0] slot_r;
   logic [4:0] ncol_r;
   logic [9:0] bo_mask;
   logic want_frm, want_any, defer, bp_need, col_new, fc_sent, set_fc;

   // Pins pass three flops; a level counts once the last two agree
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         crs_s_r <= 3'h0;
         col_s_r <= 3'h0;
         crs_q_r <= 1'b0;
         col_q_r <= 1'b0;
         col_d_r <= 1'b0;
      end
      else
      begin
         crs_s_r <= {crs_s_r[1:0], crs_i};
         col_s_r <= {col_s_r[1:0], col_i};
         if (crs_s_r[1] == crs_s_r[2])
            crs_q_r <= crs_s_r[2];
         if (col_s_r[1] == col_s_r[2])
            col_q_r <= col_s_r[2];
         col_d_r <= col_q_r;
      end
   end

   // One tick per two bit times; exact at both speeds, unlike a bit tick at 100M
   always_ff @(posedge clock_i)
   begin
      if (reset_i || pair_cnt_r == (speed_100_i ? P100_LAST : P10_LAST))
         pair_cnt_r <= 6'h00;
      else
         pair_cnt_r <= pair_cnt_r + 6'h01;
      tick_r <= !reset_i && pair_cnt_r == (speed_100_i ? P100_LAST : P10_LAST);
   end

   // Pause timer, quantum of 512 bit times
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         quant_cnt_r <= 8'h00;
         pause_r <= 16'h0000;
      end
      else
      begin
         if (tick_r)
            quant_cnt_r <= (quant_cnt_r == QUANT_LAST) ? 8'h00 : quant_cnt_r + 8'h01;
         if (rx_pause_i)
            pause_r <= rx_quanta_i;
         else if (tick_r && quant_cnt_r == QUANT_LAST && link_up_i && full_duplex_i
                  && pause_r != 16'h0000)
            pause_r <= pause_r - 16'h0001;
      end
   end

   // Buffer thresholds with hysteresis; a new request wins over a finished send
   assign set_fc = full_duplex_i && link_up_i
                   && ((!fc_active_r && free_i <= XOFF_THR) || (fc_active_r && free_i >= XON_THR));
   assign fc_sent = state_r == ST_TX && tx_end_i && cur_flow_r;
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         fc_active_r <= 1'b0;
         fc_pend_r <= 1'b0;
         fc_time_r <= `EMTX_PAUSE_ZERO;
      end
      else
      begin
         if (!fc_active_r && free_i <= XOFF_THR)
            fc_active_r <= 1'b1;
         else if (fc_active_r && free_i >= XON_THR)
            fc_active_r <= 1'b0;
         if (fc_sent)
            fc_pend_r <= 1'b0;
         if (set_fc)
         begin
            fc_pend_r <= 1'b1;
            fc_time_r <= fc_active_r ? `EMTX_PAUSE_ZERO : `EMTX_PAUSE_MAX;
         end
      end
   end

   // Free running source for back-off slots
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
         lfsr_r <= `EMTX_LFSR_SEED;
      else
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
   end

   // Scheduler qualifiers
   assign want_frm = tx_valid_i && (tx_ctrl_i || pause_r == 16'h0000);
   assign want_any = want_frm || fc_pend_r;
   assign defer = !full_duplex_i && crs_q_r;
   assign bp_need = !full_duplex_i && bp_enable_i && link_up_i && fc_active_r;
   assign col_new = !full_duplex_i && col_q_r && !col_d_r;
   // Range is 2^k - 1 slots, k capped at ten
   assign bo_mask = (ncol_r + 5'h01 >= `EMTX_BO_LIMIT) ? 10'h3FF
                    : 10'((11'h001 << (ncol_r + 5'h01)) - 11'h001);

   // Transmit scheduler
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 18'h00000;
         slot_r <= 9'h000;
         ncol_r <= 5'h00;
         after_col_r <= 1'b0;
         cur_flow_r <= 1'b0;
         cmd_o <= '0;
         evt_o <= '0;
      end
      else
      begin
         cmd_o.start <= 1'b0;
         cmd_o.abort <= 1'b0;
         cmd_o.drop <= 1'b0;
         evt_o <= '0;
         case (state_r)
            ST_IDLE:
            begin
               if (want_any && !defer)
               begin
                  state_r <= ST_TX;
                  slot_r <= 9'h000;
                  cur_flow_r <= fc_pend_r;
                  cmd_o.start <= 1'b1;
                  cmd_o.flow <= fc_pend_r;
                  cmd_o.pause_time <= fc_time_r;
               end
               else if (!want_any && bp_need)
               begin
                  state_r <= ST_BP;
                  cnt_r <= 18'h00000;
               end
            end
            ST_TX:
            begin
               if (tick_r && slot_r != SLOT_PAIRS)
                  slot_r <= slot_r + 9'h001;
               if (col_new)
               begin
                  cmd_o.abort <= 1'b1;
                  cnt_r <= 18'h00000;
                  after_col_r <= 1'b1;
                  if (slot_r == SLOT_PAIRS)
                  begin
                     cmd_o.drop <= 1'b1;
                     evt_o.late_col <= 1'b1;
                     ncol_r <= 5'h00;
                     state_r <= ST_IPG;
                  end
                  else if (ncol_r + 5'h01 == `EMTX_MAX_COL)
                  begin
                     cmd_o.drop <= 1'b1;
                     evt_o.excess_col <= 1'b1;
                     ncol_r <= 5'h00;
                     state_r <= ST_IPG;
                  end
                  else if (bp_need)
                  begin
                     ncol_r <= ncol_r + 5'h01;
                     state_r <= ST_BP;
                  end
                  else
                  begin
                     ncol_r <= ncol_r + 5'h01;
                     cnt_r <= {lfsr_r[9:0] & bo_mask, 8'h00};
                     state_r <= ST_BOFF;
                  end
               end
               else if (tx_end_i)
               begin
                  ncol_r <= 5'h00;
                  after_col_r <= 1'b0;
                  cnt_r <= 18'h00000;
                  state_r <= ST_IPG;
               end
            end
            ST_BOFF:
            begin
               if (cnt_r == 18'h00000)
                  state_r <= ST_IPG;
               else if (tick_r)
                  cnt_r <= cnt_r - 18'h00001;
            end
            ST_IPG:
            begin
               // Gap restarts while carrier is up after a collision
               if (after_col_r && crs_q_r)
                  cnt_r <= 18'h00000;
               else if (tick_r)
               begin
                  if (cnt_r == IPG_LAST)
                  begin
                     cnt_r <= 18'h00000;
                     state_r <= ST_IDLE;
                  end
                  else
                     cnt_r <= cnt_r + 18'h00001;
               end
            end
            ST_BP:
            begin
               // Collisions here are ignored: carrier simply stays up
               if (want_any)
               begin
                  cnt_r <= 18'h00000;
                  after_col_r <= 1'b0;
                  state_r <= ST_IPG;
               end
               else if (!bp_need)
                  state_r <= ST_IDLE;
               else if (tick_r)
               begin
                  if (cnt_r == BP_ON_LAST)
                  begin
                     cnt_r <= 18'h00000;
                     state_r <= ST_BPGAP;
                  end
                  else
                     cnt_r <= cnt_r + 18'h00001;
               end
            end
            ST_BPGAP:
            begin
               if (tick_r)
               begin
                  if (cnt_r == BP_GAP_LAST)
                  begin
                     cnt_r <= 18'h00000;
                     state_r <= ST_BP;
                  end
                  else
                     cnt_r <= cnt_r + 18'h00001;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Registered carrier and pause state for the datapath
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         bp_carrier_o <= 1'b0;
         paused_o <= 1'b0;
      end
      else
      begin
         bp_carrier_o <= state_r == ST_BP;
         paused_o <= pause_r != 16'h0000;
      end
   end

endmodule // emtx_mac

// ---- emtx_mac_checker.sv ----
`timescale 1ns/100ps
`include "emtx_regs.svh"
// Port watcher for the MAC
module emtx_mac_checker
   import emtx_pkg::*;
#(parameter int BP_ON_PAIRS = 2000)
(
   // Clock and modes
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic full_duplex_i,
   input wire logic speed_100_i,
   // Causes
   input wire logic tx_ctrl_i,
   input wire logic tx_end_i,
   input wire logic rx_pause_i,
   input wire logic [15:0] rx_quanta_i,
   // Outputs
   input emtx_txcmd_type cmd_o,
   input wire logic bp_carrier_o,
   input wire logic paused_o,
   input emtx_evt_type evt_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   logic [12:0] gap_r;
   logic [16:0] run_r;
   // Cycles since frame end; saturates so a first start passes
   always_ff @(posedge clock_i)
      if (reset_i) gap_r <= 13'h1FFF;
      else if (tx_end_i) gap_r <= 13'h0000;
      else if (gap_r != 13'h1FFF) gap_r <= gap_r + 13'h0001;
   // Burst length, so a stuck carrier shows
   always_ff @(posedge clock_i)
      run_r <= (reset_i || !bp_carrier_o) ? 17'h00000 : run_r + 17'h00001;
   a_ipg_after_end: assert property (
      cmd_o.start |-> gap_r >= (speed_100_i ? 13'h00F0 : 13'h0960))
      else $error("gap too short");
   a_late_drops: assert property (
      evt_o.late_col |-> cmd_o.drop) else $error("late without drop");
   a_excess_drops: assert property (
      evt_o.excess_col |-> cmd_o.drop) else $error("excess without drop");
   a_pause_loads: assert property (
      rx_pause_i && rx_quanta_i != 16'h0000 |-> ##[1:2] paused_o)
      else $error("pause not taken");
   a_pause_blocks: assert property (
      cmd_o.start && !cmd_o.flow && paused_o && $past(paused_o) |-> $past(tx_ctrl_i))
      else $error("normal frame while paused");
   a_half_hold: assert property (
      paused_o && !full_duplex_i && !$past(full_duplex_i) && !rx_pause_i
      && !$past(rx_pause_i) |=> paused_o) else $error("timer ran in half duplex");
   a_flow_value: assert property (
      cmd_o.start && cmd_o.flow |-> full_duplex_i
      && (cmd_o.pause_time == 16'hFFFF || cmd_o.pause_time == 16'h0000))
      else $error("bad flow frame");
   a_burst_bounded: assert property (
      run_r <= BP_ON_PAIRS * 50 + 8) else $error("carrier burst too long");
endmodule // emtx_mac_checker

// ---- emtx_station.sv ----
`timescale 1ns/100ps
// Remote station: collides on command, sends pause frames
module emtx_station
   import emtx_pkg::*;
(
   // Clock and our transmitter
   input wire logic clock_i,
   input emtx_txcmd_type cmd_i,
   // Bench controls
   input wire logic arm_i,
   input wire logic [11:0] col_at_i,
   input wire logic pause_i,
   input wire logic [15:0] quanta_i,
   // PHY view of the remote side
   output logic crs_o = 1'b0,
   output logic col_o = 1'b0,
   output logic rx_pause_o = 1'b0,
   output logic [15:0] rx_quanta_o = 16'h5A5A
);
   int cnt = 0;
   int hold = 0;
   // Jam is short, carrier lingers so the gap must follow it
   always @(posedge clock_i)
   begin
      cnt <= cmd_i.start ? 0 : cnt + 1;
      if (arm_i && cnt == col_at_i) hold <= 300;
      else if (hold > 0) hold <= hold - 1;
      col_o <= hold > 284;
      crs_o <= hold > 0;
   end
   // Value bus churns when no pause frame is shown
   always @(posedge clock_i)
   begin
      rx_pause_o <= pause_i;
      rx_quanta_o <= pause_i ? quanta_i : ~rx_quanta_o;
   end
endmodule // emtx_station

// ---- emtx_mac_tb_top.sv ----
`timescale 1ns/100ps
// Bench: plays queue and datapath, remote side in the station
module emtx_mac_tb_top;
   import emtx_pkg::*;
   logic clock_i = 1'b0, reset_i = 1'b1, link_up_i = 1'b1, full_duplex_i = 1'b1;
   logic speed_100_i = 1'b1, bp_enable_i = 1'b0, tx_valid_i = 1'b0, tx_ctrl_i = 1'b0;
   logic tx_end_i = 1'b0, arm = 1'b0, pause_i = 1'b0, crs_i, col_i, rx_pause_i;
   logic bp_carrier_o, paused_o;
   logic [11:0] free_i = 12'hFFF, col_at = 12'h00A;
   logic [15:0] quanta = 16'h0000, rx_quanta_i;
   emtx_txcmd_type cmd_o;
   emtx_evt_type evt_o;
   int fails = 0, n_checks = 0, cyc = 0, t, seed;
   // 250 MHz; short backpressure counts keep the run brief
   always #2 clock_i = ~clock_i;
   emtx_mac #(.BP_ON_PAIRS(20), .BP_GAP_PAIRS(4)) uut (.clock_i, .reset_i, .link_up_i,
      .full_duplex_i, .speed_100_i, .bp_enable_i, .crs_i, .col_i, .tx_valid_i, .tx_ctrl_i,
      .tx_end_i, .free_i, .rx_pause_i, .rx_quanta_i, .cmd_o, .bp_carrier_o, .paused_o, .evt_o);
   emtx_station far (.clock_i, .cmd_i(cmd_o), .arm_i(arm), .col_at_i(col_at), .pause_i,
      .quanta_i(quanta), .crs_o(crs_i), .col_o(col_i), .rx_pause_o(rx_pause_i),
      .rx_quanta_o(rx_quanta_i));
   // Compare and report
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task test_done;
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for one event; t holds the cycles spent
   function bit hit(int k);
      case (k)
         0: return cmd_o.start === 1'b1;
         1: return cmd_o.abort === 1'b1;
         2: return bp_carrier_o === 1'b1;
         3: return bp_carrier_o === 1'b0;
         default: return paused_o === 1'b0;
      endcase
   endfunction
   task wt(input int k, input int lim);
      t = 0;
      do
      begin
         @(posedge clock_i);
         t++;
      end
      while (!hit(k) && t < lim);
   endtask
   // Datapath end of frame, queue a frame, receive a pause
   task fin(input int len);
      repeat (len) @(posedge clock_i);
      tx_end_i <= 1'b1;
      @(posedge clock_i);
      tx_end_i <= 1'b0;
   endtask
   task q(input logic c);
      tx_valid_i <= 1'b1;
      tx_ctrl_i <= c;
      wt(0, 12000);
      tx_valid_i <= 1'b0;
   endtask
   task pz(input logic [15:0] v);
      pause_i <= 1'b1;
      quanta <= v;
      @(posedge clock_i);
      pause_i <= 1'b0;
   endtask
   // Hang guard
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         test_done;
      end
   end
   initial
   begin
      seed = $urandom(32'hB884);
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      // Back-to-back frames at both speeds
      for (int i = 0; i < 6; i++)
      begin
         speed_100_i <= (i < 4);
         q(1'b0);
         if (i != 0 && i != 4) chk("ipg", 1, t >= (i < 4 ? 240 : 2400));
         fin(20 + $urandom % 64);
      end
      speed_100_i <= 1'b1;
      // Second pause reloads; control frame still goes while paused
      pz(16'h0001);
      repeat (200) @(posedge clock_i);
      pz(16'h0002);
      q(1'b0);
      chk("pwait", 1, t > 1280 && t < 2700);
      fin(30);
      pz(16'h0003);
      // Let the gap after the last frame run out first
      repeat (300) @(posedge clock_i);
      q(1'b1);
      chk("ctl", 1, t < 30 && paused_o);
      fin(30);
      // Timer stands still in half duplex
      full_duplex_i <= 1'b0;
      repeat (4000) @(posedge clock_i);
      chk("hold", 1, paused_o);
      full_duplex_i <= 1'b1;
      wt(4, 5000);
      chk("expire", 0, paused_o);
      // Off frame, quiet middle band, on frame
      free_i <= 12'($urandom % 256);
      wt(0, 500);
      chk("xoff", 16'hFFFF, {cmd_o.flow, cmd_o.pause_time[14:0]});
      fin(40);
      free_i <= 12'h200;
      wt(0, 600);
      chk("band", 16'h0258, 16'(t));
      free_i <= 12'h300 + 12'($urandom % 256);
      wt(0, 600);
      chk("xon", 16'h8000, {cmd_o.flow, cmd_o.pause_time[14:0]});
      fin(40);
      // Half duplex: retries wait out remote carrier, then late drop
      full_duplex_i <= 1'b0;
      arm <= 1'b1;
      tx_ctrl_i <= 1'b0;
      tx_valid_i <= 1'b1;
      wt(0, 500);
      for (int i = 0; i < 3; i++)
      begin
         wt(1, 60);
         chk("abort", 16'h0002, {cmd_o.abort, cmd_o.drop});
         if (i == 2) arm <= 1'b0;
         wt(0, 12000);
         chk("regap", 1, t > 520 && t < 12000);
      end
      tx_valid_i <= 1'b0;
      fin(40);
      col_at <= 12'h514;
      arm <= 1'b1;
      tx_valid_i <= 1'b1;
      wt(0, 800);
      wt(1, 1400);
      chk("late", 16'h0003, {cmd_o.drop, evt_o.late_col});
      tx_valid_i <= 1'b0;
      arm <= 1'b0;
      // Backpressure burst, short gap, frame cuts in, carrier resumes
      bp_enable_i <= 1'b1;
      free_i <= 12'h080;
      wt(2, 1000);
      chk("bpon", 1, bp_carrier_o);
      wt(3, 200);
      wt(2, 60);
      chk("bpgap", 1, t > 10 && t < 40);
      q(1'b0);
      chk("bpfrm", 0, bp_carrier_o);
      fin(40);
      wt(2, 1000);
      chk("bpback", 1, bp_carrier_o);
      free_i <= 12'hFFF;
      repeat (200) @(posedge clock_i);
      chk("bpoff", 0, bp_carrier_o);
      // Collisions under backpressure skip back-off; the sixteenth drops the frame
      free_i <= 12'h080;
      col_at <= 12'h00A;
      arm <= 1'b1;
      tx_valid_i <= 1'b1;
      for (int i = 0; i < 15; i++)
      begin
         wt(1, 600);
         wt(2, 4);
         chk("bpcol", 1, bp_carrier_o);
      end
      wt(1, 600);
      chk("excess", 16'h0003, {cmd_o.drop, evt_o.excess_col});
      tx_valid_i <= 1'b0;
      arm <= 1'b0;
      test_done;
   end
endmodule // emtx_mac_tb_top

bind emtx_mac emtx_mac_checker #(.BP_ON_PAIRS(BP_ON_PAIRS)) mon (.clock_i, .reset_i,
   .full_duplex_i, .speed_100_i, .tx_ctrl_i, .tx_end_i, .rx_pause_i, .rx_quanta_i, .cmd_o,
   .bp_carrier_o, .paused_o, .evt_o);
